/* hdl/ssb_map.svh */
// Constants shared by both ends of the synchronous SRAM link.
// Assumes nothing; definitions only.
`ifndef SSB_MAP_SVH
`define SSB_MAP_SVH

// Array geometry: 1M words of four 9-bit lanes
`define SSB_ADDR_W        20
`define SSB_DEPTH         1048576
`define SSB_LANES         4
`define SSB_LANE_W        9
`define SSB_DATA_W        36
`define SSB_LANES_NONE    4'hF

// Core clock period and snooze timing
`define SSB_TKC_NS        40
`define SSB_WAKE_NS       (2 * `SSB_TKC_NS)
`define SSB_WAKE_CYCLES   (`SSB_WAKE_NS / `SSB_TKC_NS)
`define SSB_ENTER_NS      (2 * `SSB_TKC_NS)
`define SSB_ENTER_CYCLES  (`SSB_ENTER_NS / `SSB_TKC_NS)

`endif

/* hdl/ssb_pkg.sv */
// Types shared by both ends of the synchronous SRAM link.
// Assumes ssb_map.svh is on the include path.
`include "ssb_map.svh"

package ssb_pkg;
    typedef logic [`SSB_ADDR_W-1:0] ssb_addr_type;
    typedef logic [`SSB_DATA_W-1:0] ssb_word_type;
    typedef logic [`SSB_LANES-1:0]  ssb_lanes_type;
    typedef logic [1:0]             ssb_wake_type;
    // Controller power sequencing
    typedef enum logic [1:0] {
        ssb_run,
        ssb_drain,
        ssb_sleep,
        ssb_wake
    } ssb_power_type;
endpackage

/* hdl/ssb_sram_if.sv */
// Pin-level link between SRAM controller and SRAM device.
// Assumes both ends share core_clk; the data bus is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface ssb_sram_if;
    ssb_pkg::ssb_addr_type  addr;               // Address
    logic                   advance_load_n;     // Address load, low active
    logic                   chip_select_n;      // Combined select, low active
    logic                   write_n;            // Write strobe, low active
    ssb_pkg::ssb_lanes_type byte_lane_write_n;  // Lane strobes, low active
    logic                   clock_enable_n;     // High suspends the device
    logic                   sleep_request;      // Snooze, high active
    ssb_pkg::ssb_word_type  dev_dq_out;         // Device read data
    logic                   dev_dq_oe;          // Device drives bus
    ssb_pkg::ssb_word_type  ctl_dq_out;         // Controller write data
    logic                   ctl_dq_oe;          // Controller drives bus
    ssb_pkg::ssb_word_type  dq;                 // Resolved bus level

    // Undriven bus reads as zero
    assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

    modport device (
        input  addr, advance_load_n, chip_select_n, write_n,
        input  byte_lane_write_n, clock_enable_n, sleep_request, dq,
        output dev_dq_out, dev_dq_oe
    );
    modport ctrl (
        output addr, advance_load_n, chip_select_n, write_n,
        output byte_lane_write_n, clock_enable_n, sleep_request,
        output ctl_dq_out, ctl_dq_oe,
        input  dq
    );
endinterface

`default_nettype wire

/* hdl/ssb_sram_ctrl.sv */
// Controller end: turns user requests into pin cycles, returns read data,
// sequences snooze entry and wake-up and passes clock suspend through.
// Assumes the device end samples the same core_clk edges.
`timescale 1ns/1ps
`default_nettype none
`include "ssb_map.svh"

module ssb_sram_ctrl (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // Pins toward the device
    ssb_sram_if.ctrl                    link,
    // Request side
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire ssb_pkg::ssb_addr_type  req_addr,
    input  wire ssb_pkg::ssb_lanes_type req_lanes_n,
    input  wire ssb_pkg::ssb_word_type  req_wdata,
    output var  logic                   req_ready,
    // Read answer
    output var  logic                   rsp_valid,
    output var  ssb_pkg::ssb_word_type  rsp_rdata,
    // Power and suspend requests
    input  wire logic                   user_sleep,
    input  wire logic                   user_hold
);
    logic                  take;        // Request accepted this edge
    logic                  frozen;      // Device suspended this edge
    logic                  busy;        // Any cycle still in flight
    logic                  w1_valid;    // Write data, same edge as load
    logic                  w2_valid;    // Write data, one edge after load
    ssb_pkg::ssb_word_type w1_data;
    ssb_pkg::ssb_word_type w2_data;
    logic [2:0]            rd_pipe;     // Read return stages
    ssb_pkg::ssb_power_type state;
    ssb_pkg::ssb_power_type next_state;
    ssb_pkg::ssb_wake_type  wake_cnt;   // Wake-up cycles counted

    assign take   = req_valid && req_ready;
    assign frozen = link.clock_enable_n;
    assign busy   = !link.chip_select_n || w1_valid || w2_valid
                    || link.ctl_dq_oe || (rd_pipe != 3'h0);

    // Command pins; an idle cycle is an address load with select high
    always_ff @(posedge core_clk) begin
        if (reset) begin
            link.advance_load_n    <= 1'b0;
            link.chip_select_n     <= 1'b1;
            link.write_n           <= 1'b1;
            link.addr              <= '0;
            link.byte_lane_write_n <= `SSB_LANES_NONE;
        end else if (!frozen) begin
            link.advance_load_n    <= 1'b0;
            // RQ9 select valid
            link.chip_select_n     <= !take;
            // RQ5 write qualify
            link.write_n           <= !(take && req_write);
            link.addr              <= req_addr;
            link.byte_lane_write_n <= (take && req_write) ? req_lanes_n : `SSB_LANES_NONE;
        end
    end

    // Write data rides two stages so it meets the device's late capture
    always_ff @(posedge core_clk) begin
        if (reset) begin
            w1_valid        <= 1'b0;
            w2_valid        <= 1'b0;
            link.ctl_dq_oe  <= 1'b0;
            w1_data         <= '0;
            w2_data         <= '0;
            link.ctl_dq_out <= '0;
        end else if (!frozen) begin
            // RQ7 late data
            w1_valid        <= take && req_write;
            w1_data         <= req_wdata;
            w2_valid        <= w1_valid;
            w2_data         <= w1_data;
            link.ctl_dq_oe  <= w2_valid;
            link.ctl_dq_out <= w2_data;
        end
    end

    // Read return; the device holds its output while suspended
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_pipe   <= 3'h0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            // RQ6 read qualify
            rsp_valid <= rd_pipe[2] && !frozen;
            if (!frozen) begin
                rd_pipe <= {rd_pipe[1:0], take && !req_write};
                if (rd_pipe[2]) begin
                    rsp_rdata <= link.dq;
                end
            end
        end
    end

    // Power sequencing next state
    always_comb begin
        next_state = state;
        case (state)
            ssb_pkg::ssb_run: begin
                if (user_sleep) begin
                    next_state = ssb_pkg::ssb_drain;
                end
            end
            // RQ17 drain first
            ssb_pkg::ssb_drain: begin
                if (!busy) begin
                    next_state = ssb_pkg::ssb_sleep;
                end
            end
            ssb_pkg::ssb_sleep: begin
                if (!user_sleep) begin
                    next_state = ssb_pkg::ssb_wake;
                end
            end
            ssb_pkg::ssb_wake: begin
                if (wake_cnt == 2'(`SSB_WAKE_CYCLES - 1)) begin
                    next_state = ssb_pkg::ssb_run;
                end
            end
            default: begin
                next_state = ssb_pkg::ssb_run;
            end
        endcase
    end

    // Power state, sleep pin and wake counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state              <= ssb_pkg::ssb_run;
            link.sleep_request <= 1'b0;
            wake_cnt           <= '0;
        end else begin
            state              <= next_state;
            link.sleep_request <= (next_state == ssb_pkg::ssb_sleep);
            // RQ15 wake spacing
            if (state == ssb_pkg::ssb_wake) begin
                wake_cnt <= 2'(wake_cnt + 2'h1);
            end else begin
                wake_cnt <= '0;
            end
        end
    end

    // Ready and suspend pin share inputs so they never disagree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_ready           <= 1'b0;
            link.clock_enable_n <= 1'b0;
        end else begin
            req_ready           <= (next_state == ssb_pkg::ssb_run) && !user_sleep && !user_hold;
            link.clock_enable_n <= user_hold;
        end
    end
endmodule // ssb_sram_ctrl

`default_nettype wire

/* hdl/ssb_sram_device.sv */
// Device end: 1M x 36 array with byte-lane writes, late-late write
// pipeline, registered read output, clock suspend and snooze gating.
// Assumes the controller keeps chip select valid at every address load
// and has drained its traffic before raising the sleep request.
`timescale 1ns/1ps
`default_nettype none
`include "ssb_map.svh"

// Summary of operation
// RQ1 - All lane strobes low writes whole word
// RQ2 - Write with no lane strobe is no-op
// RQ3 - Each lane written only when strobed
// RQ4 - Any strobe mix writes only strobed lanes
// RQ5 - Write strobe low at load means write
// RQ6 - Write strobe high at load means read
// RQ7 - Write data captured two edges after load
// RQ8 - Read data driven after second edge
// RQ9 - Controller keeps select valid at loads
// RQ10 - Sleep request high enters snooze
// RQ11 - Snooze acts as deselected, bus released
// RQ12 - Snooze lasts while sleep request high
// RQ13 - Snooze ignores all other inputs
// RQ14 - Inputs ignored within two clock periods
// RQ15 - Two periods wake-up before sampling again
// RQ16 - Cycles in flight at snooze are dropped
// RQ17 - Controller drains traffic before sleep
// RQ18 - Suspend input freezes all registers; the wake-up counter and snooze status keep running
module ssb_sram_device (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Pins from the controller
    ssb_sram_if.device link,
    // Status
    output var  logic snooze_active
);
    // Storage array, four 9-bit lanes per word
    // Lane i holds bits 9i+8 down to 9i of each word.
    ssb_pkg::ssb_word_type  mem [0:`SSB_DEPTH-1];

    // Gating terms
    logic                   hold;          // Suspend pin high
    logic                   awake;         // Not asleep, wake-up done
    logic                   take;          // Selected address load
    logic                   take_write;    // Write with a lane strobed
    logic                   take_read;     // Read load
    logic                   commit;        // Write data captured now
    ssb_pkg::ssb_wake_type  wake_cnt;      // Cycles since sleep fell

    // First stage: command registered at the load edge
    logic                   s1_read;
    logic                   s1_write;
    ssb_pkg::ssb_addr_type  s1_addr;
    ssb_pkg::ssb_lanes_type s1_lanes;

    // Second stage: write waiting for its data
    logic                   s2_write;
    ssb_pkg::ssb_addr_type  s2_addr;
    ssb_pkg::ssb_lanes_type s2_lanes;

    // Read word with a same-edge write folded in
    ssb_pkg::ssb_word_type  next_rdata;

    // RQ18 suspend input
    // Suspend freezes both pipeline stages and the output register; the
    // wake-up counter keeps counting, like the controller's, so both ends
    // agree on when the first command after a snooze may be loaded.
    assign hold = link.clock_enable_n;

    // RQ13 gate inputs
    // RQ14 immediate ignore
    // Gating uses the sampled sleep level itself, so inputs are ignored
    // from the very edge that sees it, well inside the two-period limit.
    assign awake = !link.sleep_request && (wake_cnt == 2'(`SSB_WAKE_CYCLES));

    // RQ9 select trusted
    // Select is only looked at on load edges, where it must be valid.
    // An unknown select there would carry unknowns into both stages.
    assign take = awake && !hold && !link.advance_load_n && !link.chip_select_n;

    // RQ5 write qualify
    // RQ2 abort write
    // A write with every lane strobe high is dropped here, so it never
    // occupies the pipeline and never touches the array.
    assign take_write = take && !link.write_n && (link.byte_lane_write_n != `SSB_LANES_NONE);

    // RQ6 read qualify
    assign take_read = take && link.write_n;

    // RQ7 late capture
    assign commit = s2_write && awake && !hold;

    // Wake-up counter: reloads to zero while asleep, counts after release
    // It rests at the wake count after reset, so the device is usable from
    // the first edge; a short sleep pulse still costs the full wake-up gap.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wake_cnt <= 2'(`SSB_WAKE_CYCLES);
        end else if (link.sleep_request) begin
            // RQ10 enter snooze
            wake_cnt <= '0;
        end else if (wake_cnt != 2'(`SSB_WAKE_CYCLES)) begin
            // RQ15 wake spacing
            wake_cnt <= 2'(wake_cnt + 2'h1);
        end
    end

    // Snooze status follows the sleep request level
    // It only reports; the gating itself works from the pin, one edge ahead.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            snooze_active <= 1'b0;
        end else begin
            // RQ12 snooze duration
            snooze_active <= link.sleep_request;
        end
    end

    // First pipeline stage
    // Address and lanes load on every running edge; only the valid bits
    // decide whether they are ever used, which keeps the path short.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_read  <= 1'b0;
            s1_write <= 1'b0;
            s1_addr  <= '0;
            s1_lanes <= `SSB_LANES_NONE;
        end else if (!awake) begin
            // RQ16 drop in flight
            s1_read  <= 1'b0;
            s1_write <= 1'b0;
        end else if (!hold) begin
            // RQ18 suspend freeze
            s1_read  <= take_read;
            s1_write <= take_write;
            s1_addr  <= link.addr;
            s1_lanes <= link.byte_lane_write_n;
        end
    end

    // Second pipeline stage, writes only
    // Reads need no second stage: their data is fetched while the command
    // sits in the first one, which is what removes the turnaround cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s2_write <= 1'b0;
            s2_addr  <= '0;
            s2_lanes <= `SSB_LANES_NONE;
        end else if (!awake) begin
            // RQ16 drop in flight
            s2_write <= 1'b0;
        end else if (!hold) begin
            // RQ18 suspend freeze
            s2_write <= s1_write;
            s2_addr  <= s1_addr;
            s2_lanes <= s1_lanes;
        end
    end

    // Array write: the data sits on the bus at the edge two after the load
    // Lanes without a strobe keep their contents. The array is never
    // cleared, so a word read before it was written returns unknown.
    always_ff @(posedge core_clk) begin
        if (commit) begin
            for (int i = 0; i < `SSB_LANES; i++) begin
                // RQ1 whole word
                // RQ3 lane select
                // RQ4 any strobe mix
                if (!s2_lanes[i]) begin
                    mem[s2_addr][i*`SSB_LANE_W +: `SSB_LANE_W] <= link.dq[i*`SSB_LANE_W +: `SSB_LANE_W];
                end
            end
        end
    end

    // Read merge: a write to the same word lands at the edge the read
    // samples the array, so its lanes are forwarded to keep back-to-back
    // write then read coherent without a turnaround cycle.
    // Only the lanes that write strobes are taken from the bus.
    always_comb begin
        next_rdata = mem[s1_addr];
        for (int i = 0; i < `SSB_LANES; i++) begin
            if (commit && (s2_addr == s1_addr) && !s2_lanes[i]) begin
                next_rdata[i*`SSB_LANE_W +: `SSB_LANE_W] = link.dq[i*`SSB_LANE_W +: `SSB_LANE_W];
            end
        end
    end

    // Output register: loaded one edge after the load, driven until the next
    // The word stays on the data lines after the enable drops; only the
    // enable tells the controller whether the bus holds device data.
    // Snooze clears the enable before suspend is looked at, so a sleeping
    // device never holds the bus, whatever the suspend pin does.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            link.dev_dq_oe  <= 1'b0;
            link.dev_dq_out <= '0;
        end else if (!awake) begin
            // RQ11 release bus
            link.dev_dq_oe  <= 1'b0;
        end else if (!hold) begin
            // RQ8 read output
            link.dev_dq_oe  <= s1_read;
            if (s1_read) begin
                link.dev_dq_out <= next_rdata;
            end
        end
    end
endmodule // ssb_sram_device

`default_nettype wire

/* tb/ssb_link_chk.sv */
// Pin checker for the link between controller and device.
// Assumes it sees the interface signals and shares core_clk.
`timescale 1ns/1ps
`default_nettype none

module ssb_link_chk (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   reset,
    // Link pins
    input wire logic                   advance_load_n,
    input wire logic                   chip_select_n,
    input wire logic                   write_n,
    input wire ssb_pkg::ssb_lanes_type byte_lane_write_n,
    input wire logic                   clock_enable_n,
    input wire logic                   sleep_request,
    input wire ssb_pkg::ssb_word_type  dev_dq_out,
    input wire logic                   dev_dq_oe,
    input wire logic                   ctl_dq_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Load taken: selected, running, sleep low at this edge and the two before
    sequence s_load;
        !advance_load_n && !chip_select_n && !clock_enable_n && !sleep_request
            && !$past(sleep_request) && !$past(sleep_request, 2);
    endsequence
    // Following edge neither suspended nor asleep
    sequence s_live;
        !clock_enable_n && !sleep_request;
    endsequence

    property p_read_drive;
        s_load ##0 write_n ##1 s_live |=> dev_dq_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");
    property p_write_quiet;
        s_load ##0 !write_n ##1 s_live |=> !dev_dq_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("device drove on write");
    property p_write_data;
        s_load ##0 (!write_n && byte_lane_write_n != 4'hF) ##1 s_live |=> ctl_dq_oe;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data missing");
    property p_snooze_release;
        sleep_request |=> !dev_dq_oe;
    endproperty
    a_snooze_release: assert property (p_snooze_release) else $error("bus driven asleep");
    property p_sleep_hold;
        sleep_request [*2] |=> !dev_dq_oe [*2];
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("access while asleep");
    property p_wake_gap;
        $fell(sleep_request) |=> !dev_dq_oe [*3];
    endproperty
    a_wake_gap: assert property (p_wake_gap) else $error("access inside wake gap");
    property p_drain;
        $rose(sleep_request) |-> chip_select_n && $past(chip_select_n)
            && $past(chip_select_n, 2) && !ctl_dq_oe;
    endproperty
    a_drain: assert property (p_drain) else $error("sleep with traffic pending");
    property p_suspend;
        clock_enable_n && !sleep_request |=> $stable(dev_dq_oe) && $stable(dev_dq_out);
    endproperty
    a_suspend: assert property (p_suspend) else $error("output moved in suspend");
endmodule // ssb_link_chk

`default_nettype wire

/* tb/testbench.sv */
// Bench: controller and device joined by the link, driven from the user side.
// Assumes the design files and ssb_map.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ssb_map.svh"

module testbench;
    logic                   core_clk;      // 25 MHz clock
    logic                   reset;         // Synchronous reset
    logic                   req_valid;     // Request present
    logic                   req_write;     // Write when high
    ssb_pkg::ssb_addr_type  req_addr;      // Word address
    ssb_pkg::ssb_lanes_type req_lanes_n;   // Lane strobes
    ssb_pkg::ssb_word_type  req_wdata;     // Write data
    logic                   req_ready;     // Request accepted
    logic                   rsp_valid;     // Read answer strobe
    ssb_pkg::ssb_word_type  rsp_rdata;     // Read answer data
    logic                   user_sleep;    // Snooze request
    logic                   user_hold;     // Suspend request
    logic                   snooze_active; // Device asleep
    int                     errors;        // Mismatches
    int                     checks;        // Comparisons
    ssb_pkg::ssb_word_type  model [int];   // Expected memory
    ssb_pkg::ssb_word_type  expq [$];      // Pending read answers
    // Top address is the boundary case
    int addr_tab [4] = '{32'h0, 32'h5, 32'hABC, 32'hF_FFFF};

    ssb_sram_if link_if ();
    ssb_sram_ctrl ssb_sram_ctrl_inst (.core_clk(core_clk), .reset(reset), .link(link_if),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_lanes_n(req_lanes_n), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .user_sleep(user_sleep),
        .user_hold(user_hold));
    ssb_sram_device ssb_sram_device_inst (.core_clk(core_clk), .reset(reset),
        .link(link_if), .snooze_active(snooze_active));
    ssb_link_chk ssb_link_chk_inst (.core_clk(core_clk), .reset(reset),
        .advance_load_n(link_if.advance_load_n), .chip_select_n(link_if.chip_select_n),
        .write_n(link_if.write_n), .byte_lane_write_n(link_if.byte_lane_write_n),
        .clock_enable_n(link_if.clock_enable_n), .sleep_request(link_if.sleep_request),
        .dev_dq_out(link_if.dev_dq_out), .dev_dq_oe(link_if.dev_dq_oe),
        .ctl_dq_oe(link_if.ctl_dq_oe));

    // Free-running clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic compare_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic compare_word(input string name, input ssb_pkg::ssb_word_type exp,
                                input ssb_pkg::ssb_word_type got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("Counts: checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Step to just after the next rising edge
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // Lane merge: only strobed lanes take new data
    function automatic ssb_pkg::ssb_word_type merge(input int a, input ssb_pkg::ssb_word_type d,
                                                    input ssb_pkg::ssb_lanes_type ln);
        ssb_pkg::ssb_word_type w;
        w = model.exists(a) ? model[a] : '0;
        for (int i = 0; i < `SSB_LANES; i++) begin
            if (!ln[i]) begin
                w[i*`SSB_LANE_W +: `SSB_LANE_W] = d[i*`SSB_LANE_W +: `SSB_LANE_W];
            end
        end
        return w;
    endfunction

    // Hold one request until taken; valid stays up for back-to-back use
    task automatic issue(input logic wr, input int a, input ssb_pkg::ssb_lanes_type ln,
                         input ssb_pkg::ssb_word_type d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = ssb_pkg::ssb_addr_type'(a);
        req_lanes_n = ln;
        req_wdata = d;
        @(posedge core_clk);
        while (req_ready !== 1'b1) begin
            n++;
            if (n > 60) begin
                compare_bit("req_ready", 1'b1, req_ready);
                final_report();
            end
            @(posedge core_clk);
        end
        if (wr) begin
            model[a] = merge(a, d, ln);
        end else begin
            expq.push_back(model[a]);
        end
        #1;
    endtask

    // Wait, bounded, for every read answer
    task automatic drain();
        req_valid = 1'b0;
        for (int n = 0; n < 40 && expq.size() != 0; n++) tick();
        compare_bit("reads_drained", 1'b1, expq.size() == 0);
        if (expq.size() != 0) begin
            final_report();
        end
    endtask

    // Read answers checked in issue order
    always @(posedge core_clk) begin
        if (!reset && rsp_valid === 1'b1) begin
            if (expq.size() == 0) begin
                compare_bit("rsp_valid", 1'b0, rsp_valid);
            end else begin
                compare_word("rsp_rdata", expq.pop_front(), rsp_rdata);
            end
        end
    end

    initial begin
        errors = 0;
        checks = 0;
        reset = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_lanes_n = 4'hF;
        req_wdata = '0;
        user_sleep = 1'b0;
        user_hold = 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        reset = 1'b0;
        // Whole words back to back, then read back
        for (int i = 0; i < 4; i++) issue(1'b1, addr_tab[i], 4'h0, 36'hA_5A5A_5A50 + i);
        for (int i = 0; i < 4; i++) issue(1'b0, addr_tab[i], 4'hF, '0);
        // Each single lane, read straight after the write
        for (int i = 0; i < 4; i++) begin
            issue(1'b1, addr_tab[0], ~(4'h1 << i), 36'h1_3579_BDF0 + i);
            issue(1'b0, addr_tab[0], 4'hF, '0);
        end
        issue(1'b1, addr_tab[1], 4'hF, 36'hF_FFFF_FFFF);
        issue(1'b1, addr_tab[2], 4'h6, 36'h0_1111_2222);
        issue(1'b1, addr_tab[2], 4'h9, 36'h0_3333_4444);
        issue(1'b0, addr_tab[1], 4'hF, '0);
        issue(1'b0, addr_tab[2], 4'hF, '0);
        // Suspend with reads in flight
        issue(1'b0, addr_tab[3], 4'hF, '0);
        req_valid = 1'b0;
        user_hold = 1'b1;
        repeat (3) tick();
        compare_bit("clock_enable_n", 1'b1, link_if.clock_enable_n);
        user_hold = 1'b0;
        drain();
        // Snooze entry, refusal while asleep, then wake-up
        user_sleep = 1'b1;
        for (int n = 0; n < 20 && snooze_active !== 1'b1; n++) tick();
        compare_bit("snooze_active", 1'b1, snooze_active);
        if (snooze_active !== 1'b1) begin
            final_report();
        end
        req_valid = 1'b1;
        req_write = 1'b0;
        req_addr = ssb_pkg::ssb_addr_type'(addr_tab[2]);
        for (int n = 0; n < 4; n++) begin
            tick();
            compare_bit("req_ready", 1'b0, req_ready);
            compare_bit("sleep_request", 1'b1, link_if.sleep_request);
            compare_bit("dev_dq_oe", 1'b0, link_if.dev_dq_oe);
        end
        user_sleep = 1'b0;
        issue(1'b0, addr_tab[2], 4'hF, '0);
        issue(1'b0, addr_tab[1], 4'hF, '0);
        drain();
        compare_bit("snooze_active", 1'b0, snooze_active);
        final_report();
    end
endmodule // testbench

`default_nettype wire
